// ### core/msd_map.vh
// register offsets, bit positions and reset values of the diagnostic record
`ifndef MSD_MAP_VH
`define MSD_MAP_VH
`define MSD_OFS_SWITCHING     2'h0
`define MSD_OFS_PHASE         2'h1
`define MSD_OFS_PROTECTION    2'h2
`define MSD_OFS_CONTROL_SRC   2'h3
`define MSD_B0_READY          0
`define MSD_B0_FWD            1
`define MSD_B0_REV            2
`define MSD_B0_CB_OVL         3
`define MSD_B0_CB_DEFECT      4
`define MSD_B0_EMERG          5
`define MSD_B0_GRP_FAULT      6
`define MSD_B0_GRP_WARN       7
`define MSD_B1_NO_SUPPLY      1
`define MSD_B1_STARTING       3
`define MSD_B1_COAST          4
`define MSD_B1_BRAKE          6
`define MSD_B1_SLOW           7
`define MSD_B2_TS_OVL         0
`define MSD_B2_TS_OPEN        1
`define MSD_B2_TS_SHORT       2
`define MSD_B2_MODEL_OVL      3
`define MSD_B2_OVL_TRIP       4
`define MSD_B2_IDLE           5
`define MSD_B2_COOL           6
`define MSD_B3_INPUT_CTRL     7
`define MSD_BYTE_RESET        8'h00
`endif

// ### core/msd_trip_latch.v
// one trip flag: set by its cause, cleared by acknowledge once cause is gone
`timescale 1ns/1ns
module msd_trip_latch
(
  // clock and reset
  input  wire i_core_clk,
  input  wire i_rst,
  // cause and acknowledge
  input  wire i_cause,
  input  wire i_ack,
  // flag
  output wire o_flag
);

  reg flag_r;
  reg flag_nxt;

  // set wins over acknowledge; ack only counts once the cause has left
  always @*
  begin
    flag_nxt = flag_r;
    if (i_cause)
      flag_nxt = 1'b1;
    else if (i_ack)
      flag_nxt = 1'b0;
  end

  always @(posedge i_core_clk)
  begin
    if (i_rst)
      flag_r <= 1'b0;
    else
      flag_r <= flag_nxt;
  end

  assign o_flag = flag_r;

endmodule // msd_trip_latch

// ### core/msd_diag_status.v
// diagnostic status record, bytes 0 to 3, with snapshot read port
// Notes on behaviour
// - byte 0 bit 0 shows ready for remote operation, live.
// - byte 0 bits 1 and 2 mirror forward and reverse contact blocks.
// - contact block overload trip latches until cause gone and trip reset.
// - defective contact block latches; only power-up reset clears it.
// - byte 0 bit 5 follows emergency start active.
// - group fault latches on any error; cleared by trip/auto reset or off.
// - group warning is the OR of all pending warnings.
// - loss of supply trip latches until cause gone and trip reset.
// - starting, coast, slow, idle, cooling phases are shown live.
// - byte 1 bit 6 follows the brake output.
// - sensor and thermal model overloads shown live in byte 2.
// - open thermistor circuit shown live in byte 2 bit 1.
// - shorted thermistor circuit shown live in byte 2 bit 2.
// - overload trip latches until cause gone and trip or auto reset.
// - byte 3 bit 7 high while local inputs give control commands.
// - trip-reset-successful flag set by trip reset, cleared by a trip reset while set with ready high, or on next update.
`timescale 1ns/1ns
`include "msd_map.vh"
module msd_diag_status
(
  // clock and reset
  input  wire       i_core_clk,
  input  wire       i_rst,
  // live conditions from motor control
  input  wire       i_ready,
  input  wire       i_forward_run_flag,
  input  wire       i_reverse_run_flag,
  input  wire       i_emerg_start,
  input  wire       i_starting,
  input  wire       i_coast_down,
  input  wire       i_slow_speed,
  input  wire       i_idle_time,
  input  wire       i_cooling_time,
  input  wire       i_brake_on,
  input  wire       i_sensor_ovl,
  input  wire       i_sensor_open,
  input  wire       i_sensor_short,
  input  wire       i_model_ovl,
  input  wire       i_input_control,
  input  wire [7:0] i_warnings,
  // trip causes, levels while present
  input  wire       i_cb_overload,
  input  wire       i_cb_defect,
  input  wire       i_no_supply,
  input  wire       i_overload,
  input  wire       i_any_error,
  // acknowledges, one-cycle pulses
  input  wire       i_trip_reset,
  input  wire       i_auto_reset,
  input  wire       i_off_cmd,
  // host read port
  input  wire       i_rd_start,
  input  wire [1:0] i_rd_addr,
  output reg  [7:0] o_rd_data,
  // trip reset success indication
  output wire       o_trip_reset_ok
);

  // latched flags
  wire       cb_ovl_flag;
  wire       no_sup_flag;
  wire       ovl_flag;
  wire       grp_fault_flag;
  wire       fault_ack;
  reg        cb_defect_r;
  reg        trip_ok_r;
  reg        trip_ok_nxt;
  // live record and snapshot
  reg  [7:0] byte0;
  reg  [7:0] byte1;
  reg  [7:0] byte2;
  reg  [7:0] byte3;
  reg  [31:0] snap_r;

  // pick one byte out of a 32-bit snapshot
  function [7:0] msd_pick;
    input [31:0] rec;
    input [1:0]  idx;
    begin
      case (idx)
        `MSD_OFS_SWITCHING:   msd_pick = rec[7:0];
        `MSD_OFS_PHASE:       msd_pick = rec[15:8];
        `MSD_OFS_PROTECTION:  msd_pick = rec[23:16];
        default:              msd_pick = rec[31:24];
      endcase
    end
  endfunction

  assign fault_ack = i_trip_reset | i_auto_reset | i_off_cmd;

  // trip flags held until acknowledged after cause leaves
  msd_trip_latch u_cb_ovl
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_cause    (i_cb_overload),
    .i_ack      (i_trip_reset),
    .o_flag     (cb_ovl_flag)
  );

  msd_trip_latch u_no_sup
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_cause    (i_no_supply),
    .i_ack      (i_trip_reset),
    .o_flag     (no_sup_flag)
  );

  msd_trip_latch u_ovl
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_cause    (i_overload),
    .i_ack      (i_trip_reset | i_auto_reset),
    .o_flag     (ovl_flag)
  );

  msd_trip_latch u_grp
  (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_cause    (i_any_error),
    .i_ack      (fault_ack),
    .o_flag     (grp_fault_flag)
  );

  // defect only clears at power-up reset; no acknowledge reaches it
  always @(posedge i_core_clk)
  begin
    if (i_rst)
      cb_defect_r <= 1'b0;
    else if (i_cb_defect)
      cb_defect_r <= 1'b1;
  end

  // success flag: trip reset sets it, or clears it while set with ready high; next read update clears
  always @*
  begin
    trip_ok_nxt = trip_ok_r;
    if (i_rd_start)
      trip_ok_nxt = 1'b0;
    if (i_trip_reset)
      trip_ok_nxt = ~(trip_ok_r & i_ready);
  end

  always @(posedge i_core_clk)
  begin
    if (i_rst)
      trip_ok_r <= 1'b0;
    else
      trip_ok_r <= trip_ok_nxt;
  end

  assign o_trip_reset_ok = trip_ok_r;

  // assemble live record; reserved bits stay zero
  always @*
  begin
    byte0 = `MSD_BYTE_RESET;
    byte1 = `MSD_BYTE_RESET;
    byte2 = `MSD_BYTE_RESET;
    byte3 = `MSD_BYTE_RESET;
    byte0[`MSD_B0_READY]     = i_ready;
    byte0[`MSD_B0_FWD]       = i_forward_run_flag;
    byte0[`MSD_B0_REV]       = i_reverse_run_flag;
    byte0[`MSD_B0_CB_OVL]    = cb_ovl_flag;
    byte0[`MSD_B0_CB_DEFECT] = cb_defect_r;
    byte0[`MSD_B0_EMERG]     = i_emerg_start;
    byte0[`MSD_B0_GRP_FAULT] = grp_fault_flag;
    byte0[`MSD_B0_GRP_WARN]  = |i_warnings;
    byte1[`MSD_B1_NO_SUPPLY] = no_sup_flag;
    byte1[`MSD_B1_STARTING]  = i_starting;
    byte1[`MSD_B1_COAST]     = i_coast_down;
    byte1[`MSD_B1_BRAKE]     = i_brake_on;
    byte1[`MSD_B1_SLOW]      = i_slow_speed;
    byte2[`MSD_B2_TS_OVL]    = i_sensor_ovl;
    byte2[`MSD_B2_TS_OPEN]   = i_sensor_open;
    byte2[`MSD_B2_TS_SHORT]  = i_sensor_short;
    byte2[`MSD_B2_MODEL_OVL] = i_model_ovl;
    byte2[`MSD_B2_OVL_TRIP]  = ovl_flag;
    byte2[`MSD_B2_IDLE]      = i_idle_time;
    byte2[`MSD_B2_COOL]      = i_cooling_time;
    byte3[`MSD_B3_INPUT_CTRL] = i_input_control;
  end

  // capture whole record at read start so bytes are never torn
  always @(posedge i_core_clk)
  begin
    if (i_rst)
      snap_r <= 32'h00000000;
    else if (i_rd_start)
      snap_r <= {byte3, byte2, byte1, byte0};
  end

  // registered read data from the snapshot
  always @(posedge i_core_clk)
  begin
    if (i_rst)
      o_rd_data <= `MSD_BYTE_RESET;
    else
      o_rd_data <= msd_pick(snap_r, i_rd_addr);
  end

endmodule // msd_diag_status

// ### bench/msd_diag_checker.sv
// assertions on the status record read port
`timescale 1ns/1ns
module msd_diag_checker
(
  // clock and reset
  input wire       i_core_clk,
  input wire       i_rst,
  // watched inputs
  input wire       i_ready,
  input wire       i_forward_run_flag,
  input wire       i_reverse_run_flag,
  input wire       i_brake_on,
  input wire       i_input_control,
  input wire [7:0] i_warnings,
  input wire       i_cb_overload,
  input wire       i_trip_reset,
  input wire       i_rd_start,
  input wire [1:0] i_rd_addr,
  // watched outputs
  input wire [7:0] o_rd_data,
  input wire       o_trip_reset_ok
);
  default clocking @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  // snapshot request, then the byte index one edge later
  sequence s_rd(a);
    i_rd_start ##1 i_rd_addr == a;
  endsequence
  a_ready_bit: assert property (s_rd(2'h0) |=>
    o_rd_data[0] == $past(i_ready, 2)) else $error("ready bit wrong");
  a_dir_bits: assert property (s_rd(2'h0) |=>
    o_rd_data[1] == $past(i_forward_run_flag, 2) &&
    o_rd_data[2] == $past(i_reverse_run_flag, 2)) else $error("dir bits");
  a_warn_or: assert property (s_rd(2'h0) |=>
    o_rd_data[7] == |$past(i_warnings, 2)) else $error("warning bit");
  a_cb_trip: assert property (s_rd(2'h0) |=>
    !$past(i_cb_overload, 3) || o_rd_data[3]) else $error("cb trip");
  a_brake_bit: assert property (s_rd(2'h1) |=>
    o_rd_data[6] == $past(i_brake_on, 2)) else $error("brake bit");
  a_ctrl_src: assert property (s_rd(2'h3) |=>
    o_rd_data == {$past(i_input_control, 2), 7'h00}) else $error("byte 3");
  a_tok_set: assert property (i_trip_reset && !o_trip_reset_ok
    |=> o_trip_reset_ok) else $error("trip ok not set");
  a_tok_clear: assert property (i_rd_start && !i_trip_reset
    |=> !o_trip_reset_ok) else $error("trip ok not cleared");
endmodule // msd_diag_checker

bind msd_diag_status msd_diag_checker u_chk (.*);

// ### bench/msd_host_model.sv
// host model reading the four status bytes as one record
`timescale 1ns/1ns
module msd_host_model
(
  // clock
  input  wire       i_core_clk,
  // read port of the status block
  output reg        o_rd_start,
  output reg  [1:0] o_rd_addr,
  input  wire [7:0] i_rd_data
);
  initial o_rd_start = 1'b0;
  initial o_rd_addr = 2'h0;
  // one request, then bytes 0..3 taken one cycle after each index
  task read_rec(output [31:0] r);
    integer k;
    begin
      @(negedge i_core_clk) o_rd_start = 1'b1;
      @(negedge i_core_clk) o_rd_start = 1'b0;
      for (k = 0; k < 4; k = k + 1)
      begin
        o_rd_addr = k[1:0];
        @(negedge i_core_clk) r[8*k +: 8] = i_rd_data;
      end
    end
  endtask
endmodule // msd_host_model

// ### bench/msd_diag_status_test.sv
// self-checking bench for the diagnostic status record
`timescale 1ns/1ns
module msd_diag_status_test;
  reg         clk;
  reg         rst;
  reg  [14:0] lv;
  reg  [7:0]  wr;
  reg  [4:0]  cs;
  reg  [2:0]  ak;
  reg  [31:0] rec;
  wire        rd_start;
  wire [1:0]  rd_addr;
  wire [7:0]  rd_data;
  wire        tok;
  integer     errors;
  integer     compares;
  integer     i;
  msd_host_model host (.i_core_clk(clk), .o_rd_start(rd_start),
    .o_rd_addr(rd_addr), .i_rd_data(rd_data));
  msd_diag_status dut (.i_core_clk(clk), .i_rst(rst), .i_ready(lv[0]),
    .i_forward_run_flag(lv[1]), .i_reverse_run_flag(lv[2]),
    .i_emerg_start(lv[3]), .i_starting(lv[4]), .i_coast_down(lv[5]),
    .i_slow_speed(lv[6]), .i_idle_time(lv[7]), .i_cooling_time(lv[8]),
    .i_brake_on(lv[9]), .i_sensor_ovl(lv[10]), .i_sensor_open(lv[11]),
    .i_sensor_short(lv[12]), .i_model_ovl(lv[13]),
    .i_input_control(lv[14]), .i_warnings(wr), .i_cb_overload(cs[0]),
    .i_cb_defect(cs[1]), .i_no_supply(cs[2]), .i_overload(cs[3]),
    .i_any_error(cs[4]), .i_trip_reset(ak[0]), .i_auto_reset(ak[1]),
    .i_off_cmd(ak[2]), .i_rd_start(rd_start), .i_rd_addr(rd_addr),
    .o_rd_data(rd_data), .o_trip_reset_ok(tok));
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  // expected record from live inputs and latched flags
  function [31:0] exp_rec(input [4:0] lf);
    exp_rec = {lv[14], 7'h00, 1'b0, lv[8], lv[7], lf[3], lv[13:10],
      lv[6], lv[9], 1'b0, lv[5], lv[4], 1'b0, lf[2], 1'b0,
      |wr, lf[4], lv[3], lf[1], lf[0], lv[2:0]};
  endfunction
  task chk(input [47:0] nm, input [31:0] e, input [31:0] g);
    begin
      compares = compares + 1;
      if (g !== e)
      begin
        errors = errors + 1;
        $display("mismatch %0s exp %h got %h", nm, e, g);
      end
    end
  endtask
  task rd_chk(input [4:0] lf);
    begin
      host.read_rec(rec);
      chk("record", exp_rec(lf), rec);
    end
  endtask
  // one-cycle acknowledge pulse
  task pa(input [2:0] a);
    begin
      @(negedge clk) ak = a;
      @(negedge clk) ak = 3'h0;
    end
  endtask
  task do_reset;
    begin
      rst = 1'b1;
      repeat (4) @(negedge clk);
      rst = 1'b0;
    end
  endtask
  // walking one over every live bit and warning
  task t_live;
    for (i = 0; i < 23; i = i + 1)
    begin
      lv = (i < 15) ? 15'h1 << i : 15'h0000;
      wr = (i > 14) ? 8'h01 << (i - 15) : 8'h00;
      rd_chk(5'h00);
    end
  endtask
  // each latch: all acks with cause high, then the acks that do not clear it, then those that do
  task t_latch;
    reg [2:0] m;
    begin
      for (i = 0; i < 5; i = i + 1)
      begin
        m = (i == 1) ? 3'h0 : (i == 3) ? 3'h3 : (i == 4) ? 3'h7 : 3'h1;
        cs[i] = 1'b1;
        pa(3'h7);
        cs[i] = 1'b0;
        rd_chk((5'h01 << i) | {3'h0, i > 1, 1'b0});
        pa(~m);
        rd_chk((5'h01 << i) | {3'h0, i > 1, 1'b0});
        pa(m);
        rd_chk((i > 0) ? 5'h02 : 5'h00);
      end
      do_reset;
      rd_chk(5'h00);
    end
  endtask
  // inputs change while the bytes are being read
  task t_snap;
    reg [31:0] e;
    begin
      lv = 15'h2AAA;
      wr = 8'h81;
      e = exp_rec(5'h00);
      fork
        host.read_rec(rec);
        #60 lv = 15'h5555;
      join
      chk("snap", e, rec);
    end
  endtask
  task t_tok;
    begin
      lv = 15'h0000;
      pa(3'h1);
      chk("tok", 32'h1, {31'h0, tok});
      pa(3'h1);
      chk("tok", 32'h1, {31'h0, tok});
      lv = 15'h0001;
      pa(3'h1);
      chk("tok", 32'h0, {31'h0, tok});
      pa(3'h1);
      host.read_rec(rec);
      chk("tok", 32'h0, {31'h0, tok});
    end
  endtask
  task conclude;
    begin
      if (errors == 0 && compares > 0)
        $display("ALL TESTS PASSED");
      else
        $display("TESTS FAILED");
      $finish;
    end
  endtask
  initial
  begin
    errors = 0;
    compares = 0;
    lv = 15'h0000;
    wr = 8'h00;
    cs = 5'h00;
    ak = 3'h0;
    do_reset;
    rd_chk(5'h00);
    t_live;
    t_latch;
    t_snap;
    t_tok;
    conclude;
  end
  // hang guard, far beyond the few hundred cycles the tests need
  initial
  begin
    #200000;
    errors = errors + 1;
    conclude;
  end
endmodule // msd_diag_status_test
